// ### core/pafo_override.sv
// per-pin override generation for ports a, b and d
`include "pafo_params.svh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - porta 7:4 feed external and pin-change interrupts
// - porta 3:0 pin-change inputs plus analog channels
// - porta 7:4 input enable follows irq enable
// - pin 4 to analog ch4; 3:0 zero overrides
// - portb 7:6 value override from compare outputs
// - portb 5:4 pin-change only, zero overrides
// - test port takes portb 3:0
// - tck tms tdi pulled up, undriven, input off
// - tdo driven only while shifting, no pullup
// - test logic clocked from tck pin
// - tms steers test controller
// - tdi shifts into selected scan chain
// - portd pin 0 feeds timer clock
// - portd 1:0 zero overrides
// - no toggle override on porta
// - pullup follows override or default term
// - driver follows direction override when enabled
// - value override when enabled and driving
// - input enable follows override when enabled
module pafo_override (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             arst_n,
   // pads (raw inputs, synchronised twice in here)
   input  wire logic [7:0]       porta_pad_in,
   input  wire logic [7:0]       portb_pad_in,
   input  wire logic [1:0]       portd_pad_in,
   // peripheral enables and values
   input  wire logic [3:0]       ext_irq_enable,
   input  wire logic             timer_cmp_en_a,
   input  wire logic             timer_cmp_en_b,
   input  wire logic             timer_cmp_out_a,
   input  wire logic             timer_cmp_out_b,
   input  wire logic             test_port_enabled,
   input  wire logic             shifting_instr_reg,
   input  wire logic             shifting_data_reg,
   input  wire logic             test_data_out,
   // port registers and global state
   input  wire logic [7:0]       porta_dir,
   input  wire logic [7:0]       porta_data,
   input  wire logic [7:0]       portb_dir,
   input  wire logic [7:0]       portb_data,
   input  wire logic [1:0]       portd_dir,
   input  wire logic [1:0]       portd_data,
   input  wire logic             global_pullup_disable,
   input  wire logic             sleep_input_off,
   // overrides to the generic pin logic
   output logic [7:0]            porta_pullup_ovr_en,
   output logic [7:0]            porta_pullup_ovr_val,
   output logic [7:0]            porta_dir_ovr_en,
   output logic [7:0]            porta_dir_ovr_val,
   output logic [7:0]            porta_value_ovr_en,
   output logic [7:0]            porta_value_ovr_val,
   output logic [7:0]            porta_toggle_ovr_en,
   output logic [7:0]            porta_input_en_ovr_en,
   output logic [7:0]            porta_input_en_ovr_val,
   output logic [7:0]            portb_pullup_ovr_en,
   output logic [7:0]            portb_pullup_ovr_val,
   output logic [7:0]            portb_dir_ovr_en,
   output logic [7:0]            portb_dir_ovr_val,
   output logic [7:0]            portb_value_ovr_en,
   output logic [7:0]            portb_value_ovr_val,
   output logic [7:0]            portb_input_en_ovr_en,
   output logic [7:0]            portb_input_en_ovr_val,
   output logic [1:0]            portd_ovr_any,
   // resolved pin controls (pad out, pad oe_n, pullup, input enable)
   output logic [7:0]            porta_pin_out,
   output logic [7:0]            porta_pin_oe_n,
   output logic [7:0]            porta_pullup_on,
   output logic [7:0]            porta_input_on,
   output logic [7:0]            portb_pin_out,
   output logic [7:0]            portb_pin_oe_n,
   output logic [7:0]            portb_pullup_on,
   output logic [7:0]            portb_input_on,
   output logic [1:0]            portd_pin_out,
   output logic [1:0]            portd_pin_oe_n,
   output logic [1:0]            portd_pullup_on,
   // alternate function inputs
   output logic [3:0]            ext_irq_in,
   output logic [15:0]           pin_change_in,
   output logic [4:0]            pin_analog_sel,
   output logic                  test_clk_in,
   output logic                  test_mode_sel_in,
   output logic                  test_data_in,
   output logic                  timer_ext_clk_in
);
////////////////////////////////////////////////////////////////////////////////
   // pads are registered twice so nothing downstream sees a metastable level
   pafo_pkg::pafo_byte_t pa_s1_q, pa_s1_d, pa_s2_q, pa_s2_d;
   pafo_pkg::pafo_byte_t pb_s1_q, pb_s1_d, pb_s2_q, pb_s2_d;
   pafo_pkg::pafo_pair_t pd_s1_q, pd_s1_d, pd_s2_q, pd_s2_d;

   always_comb
   begin
      pa_s1_d = porta_pad_in;
      pa_s2_d = pa_s1_q;
      pb_s1_d = portb_pad_in;
      pb_s2_d = pb_s1_q;
      pd_s1_d = portd_pad_in;
      pd_s2_d = pd_s1_q;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pa_s1_q <= `PAFO_ZERO8;
         pa_s2_q <= `PAFO_ZERO8;
         pb_s1_q <= `PAFO_ZERO8;
         pb_s2_q <= `PAFO_ZERO8;
         pd_s1_q <= `PAFO_ZERO2;
         pd_s2_q <= `PAFO_ZERO2;
      end
      else
      begin
         pa_s1_q <= pa_s1_d;
         pa_s2_q <= pa_s2_d;
         pb_s1_q <= pb_s1_d;
         pb_s2_q <= pb_s2_d;
         pd_s1_q <= pd_s1_d;
         pd_s2_q <= pd_s2_d;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // overrides: no registers on purpose, an enable acts at once
   always_comb
   begin
      porta_pullup_ovr_en    = `PAFO_ZERO8;
      porta_pullup_ovr_val   = `PAFO_ZERO8;
      porta_dir_ovr_en       = `PAFO_ZERO8;
      porta_dir_ovr_val      = `PAFO_ZERO8;
      porta_value_ovr_en     = `PAFO_ZERO8;
      porta_value_ovr_val    = `PAFO_ZERO8;
      porta_toggle_ovr_en    = `PAFO_ZERO8;
      porta_input_en_ovr_en  = {ext_irq_enable, 4'h0};
      porta_input_en_ovr_val = {ext_irq_enable, 4'h0};
      portb_value_ovr_en     = `PAFO_ZERO8;
      portb_value_ovr_val    = `PAFO_ZERO8;
      portb_value_ovr_en[`PAFO_PB_CMPB]  = timer_cmp_en_b;
      portb_value_ovr_en[`PAFO_PB_CMPA]  = timer_cmp_en_a;
      portb_value_ovr_val[`PAFO_PB_CMPB] = timer_cmp_out_b;
      portb_value_ovr_val[`PAFO_PB_CMPA] = timer_cmp_out_a;
      portb_pullup_ovr_en    = `PAFO_ZERO8;
      portb_pullup_ovr_val   = `PAFO_ZERO8;
      portb_dir_ovr_en       = `PAFO_ZERO8;
      portb_dir_ovr_val      = `PAFO_ZERO8;
      portb_input_en_ovr_en  = `PAFO_ZERO8;
      portb_input_en_ovr_val = `PAFO_ZERO8;
      if (test_port_enabled)
      begin
         portb_pullup_ovr_en  = `PAFO_TEST_MASK;
         portb_pullup_ovr_val = `PAFO_TEST_PUV;
         portb_dir_ovr_en     = `PAFO_TEST_MASK;
         portb_dir_ovr_val[`PAFO_PB_TDO] =
            shifting_instr_reg | shifting_data_reg;
         portb_value_ovr_en[`PAFO_PB_TDO]  = 1'b1;
         portb_value_ovr_val[`PAFO_PB_TDO] = test_data_out;
         portb_input_en_ovr_en = `PAFO_TEST_MASK;
      end
      portd_ovr_any = `PAFO_ZERO2;
   end
////////////////////////////////////////////////////////////////////////////////
   // generic resolution per pin
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         porta_pullup_on[i] = porta_pullup_ovr_en[i] ? porta_pullup_ovr_val[i]
            : (!porta_dir[i] && porta_data[i] && !global_pullup_disable);
         portb_pullup_on[i] = portb_pullup_ovr_en[i] ? portb_pullup_ovr_val[i]
            : (!portb_dir[i] && portb_data[i] && !global_pullup_disable);
         porta_pin_oe_n[i] = !(porta_dir_ovr_en[i] ? porta_dir_ovr_val[i]
            : porta_dir[i]);
         portb_pin_oe_n[i] = !(portb_dir_ovr_en[i] ? portb_dir_ovr_val[i]
            : portb_dir[i]);
         porta_pin_out[i] = porta_value_ovr_en[i] ? porta_value_ovr_val[i]
            : porta_data[i];
         portb_pin_out[i] = portb_value_ovr_en[i] ? portb_value_ovr_val[i]
            : portb_data[i];
         porta_input_on[i] = porta_input_en_ovr_en[i]
            ? porta_input_en_ovr_val[i] : !sleep_input_off;
         portb_input_on[i] = portb_input_en_ovr_en[i]
            ? portb_input_en_ovr_val[i] : !sleep_input_off;
      end
      for (int j = 0; j < 2; j++)
      begin
         portd_pullup_on[j] = !portd_dir[j] && portd_data[j]
            && !global_pullup_disable;
         portd_pin_oe_n[j]  = !portd_dir[j];
         portd_pin_out[j]   = portd_data[j];
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // alternate function inputs from the synchronised pads; analog select from pin direction
   always_comb
   begin
      ext_irq_in     = pa_s2_q[7:`PAFO_PA_IRQ_LO]
                       & porta_input_on[7:`PAFO_PA_IRQ_LO];
      pin_change_in  = {pb_s2_q & portb_input_on,
                        pa_s2_q & porta_input_on};
      // analog select marks channels whose pad is free of digital drive
      pin_analog_sel = {porta_pin_oe_n[`PAFO_PA_ADC_PIN],
                        porta_pin_oe_n[3:0]};
      // tap clocks come raw-synchronised; the tap runs in its own block
      test_clk_in      = test_port_enabled & pb_s2_q[`PAFO_PB_TCK];
      test_mode_sel_in = test_port_enabled & pb_s2_q[`PAFO_PB_TMS];
      test_data_in     = test_port_enabled & pb_s2_q[`PAFO_PB_TDI];
      timer_ext_clk_in = pd_s2_q[`PAFO_PD_TCLK];
   end
////////////////////////////////////////////////////////////////////////////////
   tdo_drive_a: assert property (@(posedge clock) disable iff (!arst_n)
      test_port_enabled |-> (portb_pin_oe_n[`PAFO_PB_TDO] ==
         !(shifting_instr_reg | shifting_data_reg)))
      else $error("tdo driver mismatch");
   test_pull_a: assert property (@(posedge clock) disable iff (!arst_n)
      test_port_enabled |-> (portb_pullup_on[3:1] == 3'h7) && !portb_pullup_on[0])
      else $error("test pin pull-up wrong");
   cmp_b_a: assert property (@(posedge clock) disable iff (!arst_n)
      (timer_cmp_en_b && !portb_pin_oe_n[`PAFO_PB_CMPB])
         |-> portb_pin_out[`PAFO_PB_CMPB] == timer_cmp_out_b)
      else $error("compare b not on pin");
   irq_ie_a: assert property (@(posedge clock) disable iff (!arst_n)
      porta_input_en_ovr_en[7:`PAFO_PA_IRQ_LO] == ext_irq_enable)
      else $error("irq input enable wrong");
   toggle_a: assert property (@(posedge clock) disable iff (!arst_n)
      porta_toggle_ovr_en == `PAFO_ZERO8)
      else $error("porta toggle override set");
   tclk_a: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(portd_pad_in[0]) |-> ##2 timer_ext_clk_in)
      else $error("timer clock lag wrong");
   pb_low_a: assert property (@(posedge clock) disable iff (!arst_n)
      portb_value_ovr_en[5:4] == 2'h0 && portb_input_en_ovr_en[7:4] == 4'h0)
      else $error("portb 5:4 override set");
   pullup_a: assert property (@(posedge clock) disable iff (!arst_n)
      (!test_port_enabled && global_pullup_disable) |-> portb_pullup_on == 8'h00)
      else $error("pull-up ignores disable");
endmodule
`default_nettype wire

// ### core/pafo_params.svh
// constants for the port alternate function override block
`ifndef PAFO_PARAMS_SVH
`define PAFO_PARAMS_SVH
`define PAFO_PA_IRQ_LO   4
`define PAFO_PA_ADC_PIN  4
`define PAFO_PB_CMPB     7
`define PAFO_PB_CMPA     6
`define PAFO_PB_TCK      3
`define PAFO_PB_TMS      2
`define PAFO_PB_TDI      1
`define PAFO_PB_TDO      0
`define PAFO_PD_TCLK     0
`define PAFO_ZERO8       8'h00
`define PAFO_ZERO2       2'h0
`define PAFO_TEST_MASK   8'h0F
`define PAFO_TEST_PUV    8'h0E
`define PAFO_IRQ_MASK    8'hF0
`endif

// ### core/pafo_pkg.sv
// types for the port alternate function override block
package pafo_pkg;
   typedef logic [7:0] pafo_byte_t;
   typedef logic [1:0] pafo_pair_t;
endpackage

// ### sim/pafo_pad_model.sv
// pad model: external drivers and pull-ups facing the override block
`timescale 1ns/1ps
`default_nettype none
module pafo_pad_model #(
   parameter int W = 8
) (
   // far side drive
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   // device side
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe_n,
   input  wire logic [W-1:0] pullup_on,
   output logic      [W-1:0] pad
);
   // a floating pad reads 1 when pulled up, else the inverse of the far value, so 0 when ext_val is 1 and no pull-up
   assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
      | (pin_oe_n & ~ext_en & (pullup_on | ~ext_val));
endmodule
`default_nettype wire

// ### sim/tb.sv
// testbench for the port alternate function override block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 1'h0, arst_n = 1'h0;
   logic [3:0] ext_irq_enable = 4'h0;
   logic timer_cmp_en_a = 1'h0, timer_cmp_en_b = 1'h0;
   logic timer_cmp_out_a = 1'h0, timer_cmp_out_b = 1'h0;
   logic test_port_enabled = 1'h0, test_data_out = 1'h0;
   logic shifting_instr_reg = 1'h0, shifting_data_reg = 1'h0;
   logic global_pullup_disable = 1'h0, sleep_input_off = 1'h0;
   logic [7:0] porta_dir = 8'h00, porta_data = 8'h00;
   logic [7:0] portb_dir = 8'h00, portb_data = 8'h00;
   logic [1:0] portd_dir = 2'h0, portd_data = 2'h0;
   logic [7:0] a_en = 8'h00, a_val = 8'h00, b_en = 8'h00, b_val = 8'h00;
   logic [1:0] d_en = 2'h0, d_val = 2'h0;
   logic [7:0] porta_pad_in, portb_pad_in;
   logic [1:0] portd_pad_in;
   logic [7:0] porta_pullup_ovr_en, porta_pullup_ovr_val, porta_dir_ovr_en;
   logic [7:0] porta_dir_ovr_val, porta_value_ovr_en, porta_value_ovr_val;
   logic [7:0] porta_toggle_ovr_en, porta_input_en_ovr_en;
   logic [7:0] porta_input_en_ovr_val, portb_pullup_ovr_en;
   logic [7:0] portb_pullup_ovr_val, portb_dir_ovr_en, portb_dir_ovr_val;
   logic [7:0] portb_value_ovr_en, portb_value_ovr_val;
   logic [7:0] portb_input_en_ovr_en, portb_input_en_ovr_val;
   logic [7:0] porta_pin_out, porta_pin_oe_n, porta_pullup_on, porta_input_on;
   logic [7:0] portb_pin_out, portb_pin_oe_n, portb_pullup_on, portb_input_on;
   logic [1:0] portd_ovr_any, portd_pin_out, portd_pin_oe_n, portd_pullup_on;
   logic [3:0] ext_irq_in;
   logic [15:0] pin_change_in;
   logic [4:0] pin_analog_sel;
   logic test_clk_in, test_mode_sel_in, test_data_in, timer_ext_clk_in;
   int fail_count = 0, checks = 0, cycles = 0;
   wire logic [55:0] pa_ovr = {porta_pullup_ovr_en, porta_pullup_ovr_val,
      porta_dir_ovr_en, porta_dir_ovr_val, porta_value_ovr_en,
      porta_value_ovr_val, porta_toggle_ovr_en};
   wire logic [31:0] pb_lo = {portb_pullup_ovr_en[3:0],
      portb_pullup_ovr_val[3:0], portb_dir_ovr_en[3:0],
      portb_dir_ovr_val[3:0], portb_value_ovr_en[3:0],
      portb_value_ovr_val[3:0], portb_input_en_ovr_en[3:0],
      portb_input_en_ovr_val[3:0]};
   wire logic [23:0] pb_hi = {portb_pullup_ovr_en[7:4],
      portb_pullup_ovr_val[7:4], portb_dir_ovr_en[7:4],
      portb_dir_ovr_val[7:4], portb_input_en_ovr_en[7:4],
      portb_input_en_ovr_val[7:4]};
   wire logic [8:0] pb_pins = {portb_pin_oe_n[3:0], portb_pullup_on[3:0],
      portb_pin_out[0]};
   wire logic [2:0] tap_in = {test_clk_in, test_mode_sel_in, test_data_in};

   pafo_override i_dut (.clock, .arst_n, .porta_pad_in, .portb_pad_in,
      .portd_pad_in, .ext_irq_enable, .timer_cmp_en_a, .timer_cmp_en_b,
      .timer_cmp_out_a, .timer_cmp_out_b, .test_port_enabled,
      .shifting_instr_reg, .shifting_data_reg, .test_data_out, .porta_dir,
      .porta_data, .portb_dir, .portb_data, .portd_dir, .portd_data,
      .global_pullup_disable, .sleep_input_off, .porta_pullup_ovr_en,
      .porta_pullup_ovr_val, .porta_dir_ovr_en, .porta_dir_ovr_val,
      .porta_value_ovr_en, .porta_value_ovr_val, .porta_toggle_ovr_en,
      .porta_input_en_ovr_en, .porta_input_en_ovr_val, .portb_pullup_ovr_en,
      .portb_pullup_ovr_val, .portb_dir_ovr_en, .portb_dir_ovr_val,
      .portb_value_ovr_en, .portb_value_ovr_val, .portb_input_en_ovr_en,
      .portb_input_en_ovr_val, .portd_ovr_any, .porta_pin_out,
      .porta_pin_oe_n, .porta_pullup_on, .porta_input_on, .portb_pin_out,
      .portb_pin_oe_n, .portb_pullup_on, .portb_input_on, .portd_pin_out,
      .portd_pin_oe_n, .portd_pullup_on, .ext_irq_in, .pin_change_in,
      .pin_analog_sel, .test_clk_in, .test_mode_sel_in, .test_data_in,
      .timer_ext_clk_in);
   pafo_pad_model #(.W(8)) i_pad_a (.ext_en(a_en), .ext_val(a_val),
      .pin_out(porta_pin_out), .pin_oe_n(porta_pin_oe_n),
      .pullup_on(porta_pullup_on), .pad(porta_pad_in));
   pafo_pad_model #(.W(8)) i_pad_b (.ext_en(b_en), .ext_val(b_val),
      .pin_out(portb_pin_out), .pin_oe_n(portb_pin_oe_n),
      .pullup_on(portb_pullup_on), .pad(portb_pad_in));
   pafo_pad_model #(.W(2)) i_pad_d (.ext_en(d_en), .ext_val(d_val),
      .pin_out(portd_pin_out), .pin_oe_n(portd_pin_oe_n),
      .pullup_on(portd_pullup_on), .pad(portd_pad_in));

   task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      forever #2 clock = ~clock;
   end
   // a hang shows up as a mismatch rather than an endless run
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fail_count++;
         finish_test();
      end
   end

   initial
   begin
      step(16);
      arst_n = 1'h1;
      step(1);
      ext_irq_enable = 4'hA;
      #1 chk("pa_ovr", 64'h0, pa_ovr);
      chk("pa_ie_en", 8'hA0, porta_input_en_ovr_en);
      chk("pa_ie_val", 8'hA0, porta_input_en_ovr_val);
      step(1);
      sleep_input_off = 1'h1;
      porta_data = 8'hFF;
      #1 chk("pa_in_on", 8'hA0, porta_input_on);
      chk("pa_pu", 8'hFF, porta_pullup_on);
      step(1);
      sleep_input_off = 1'h0;
      global_pullup_disable = 1'h1;
      #1 chk("pa_pu_off", 8'h00, porta_pullup_on);
      step(1);
      global_pullup_disable = 1'h0;
      porta_dir = 8'h0F;
      #1 chk("pa_pu_dir", 8'hF0, porta_pullup_on);
      chk("pa_oe_n", 8'hF0, porta_pin_oe_n);
      chk("pa_out", 8'hFF, porta_pin_out);
      chk("pa_adc", 5'h10, pin_analog_sel);
      step(1);
      porta_dir = 8'h00;
      {a_en, a_val} = 16'hFF81;
      step(3);
      chk("irq_in", 4'h8, ext_irq_in);
      chk("pc_a", 8'h81, pin_change_in[7:0]);
      portb_dir = 8'hC0;
      {timer_cmp_en_a, timer_cmp_en_b, timer_cmp_out_b} = 3'h7;
      {b_en, b_val} = 16'h3020;
      #1 chk("pb_hi", 24'h0, pb_hi);
      chk("pb_val_en", 8'hC0, portb_value_ovr_en);
      chk("pb_val", 8'h80, portb_value_ovr_val);
      chk("pb_oc", 4'h8, {portb_pin_out[7:6], portb_pin_oe_n[7:6]});
      step(3);
      chk("pc_b", 8'hAF, pin_change_in[15:8]);
      {test_port_enabled, shifting_data_reg, test_data_out} = 3'h7;
      {b_en, b_val} = 16'h0E0A;
      #1 chk("pb_test", 32'hFEF111F0, pb_lo);
      chk("pb_pins", 9'h1DD, pb_pins);
      step(3);
      chk("tap_in", 3'h5, tap_in);
      chk("pc_tap", 4'h0, pin_change_in[11:8]);
      b_val = 8'h04;
      step(3);
      chk("tap_in", 3'h2, tap_in);
      for (int i = 0; i < 4; i++)
      begin
         step(1);
         {shifting_instr_reg, shifting_data_reg} = i[1:0];
         #1 chk("tdo_oe_n", i == 0, portb_pin_oe_n[0]);
      end
      step(1);
      test_port_enabled = 1'h0;
      {portd_data, d_en, d_val} = 6'h3F;
      #1 chk("pd", 4'h3, {portd_ovr_any, portd_pullup_on});
      chk("pd_pin", 4'hF, {portd_pin_out, portd_pin_oe_n});
      step(3);
      chk("t0_hi", 1'h1, timer_ext_clk_in);
      d_val = 2'h2;
      step(3);
      chk("t0_lo", 1'h0, timer_ext_clk_in);
      // a real rising pad edge, so the lag assertion has work to do
      d_val = 2'h3;
      step(1);
      chk("t0_lag", 1'h0, timer_ext_clk_in);
      step(1);
      chk("t0_rise", 1'h1, timer_ext_clk_in);
      finish_test();
   end
endmodule
`default_nettype wire
